// File: logic/u485_ctl.sv
// Contract
// (R1) flag cts change; interrupt if enabled
// (R2) turnaround delay 0..15 bit times
// (R3) delay writes need enhanced enable
// (R4) transmitter disable halts shifter, keeps fifo
// (R5) software keeps tx enabled for immediate send
// (R6) receiver disable finishes current character
// (R7) re-enable receiver; idle line gives clean data
// (R8) software re-enables receiver only when idle
// (R9) receive fifo always readable
// (R10) tx disable mode governs flow characters
// (R11) rx disable mode governs flow characters
// (R12) scratch byte read/write, resets to ff
// (R13) trigger table select; a-c next-level hysteresis
// (R14) rs485 mode overrides auto flow on pin
// (R15) flow select picks rts or dtr
// (R16) direction high on load, low after stop
// (R17) tx interrupt source follows rs485 mode
// (R18) flow characters alone keep direction unchanged
// (R19) infrared receive polarity select
// (R20) enhanced enable gates enhanced writes
// (R21) status read clears delta cts
// (R22) bit time equals baud bit period
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module u485_ctl #(
    parameter int unsigned BIT_CYCLES = 16
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    // axi4-lite write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    // axi4-lite read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // uart core status
    input  wire logic        tx_load,
    input  wire logic        thr_empty,
    input  wire logic        tx_fifo_empty,
    input  wire logic        tsr_empty,
    input  wire logic        flow_char_pending,
    input  wire logic        flow_char_sent,
    input  wire logic        rx_busy,
    input  wire logic        auto_flow_deassert,
    // uart core control
    output logic             tx_halt,
    output logic             flow_tx_allow,
    output logic             rx_halt,
    output logic             rx_data_accept,
    output logic             rx_flow_accept,
    output logic [1:0]       trigger_table,
    output logic             next_level_hyst,
    output logic             tx_irq,
    output logic             modem_irq,
    // serial pins
    input  wire logic        cts_n,
    input  wire logic        ir_rx_in,
    output logic             ir_rx_data,
    output logic             rts_n,
    output logic             dtr_n
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]           turn_ctl_q;
    logic [7:0]           scratch_q;
    logic [7:0]           feature_q;
    logic [7:0]           enhanced_q;
    logic [7:0]           modem_ctl_q;
    logic                 cts_q;
    logic                 dcts_q;
    u485_pkg::u485_dir_t  dir_q;
    u485_pkg::u485_dir_t  dir_d;
    logic                 tx_idle_q;
    logic                 flow_pend_q;
    logic                 tx_dis_prev_q;
    logic                 rx_halt_q;
    logic                 awready_q;
    logic                 wready_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 arready_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;
    logic [7:0]           aw_addr_q;
    logic [7:0]           w_data_q;
    logic                 w_lane0_q;
    logic                 tx_halt_q;
    logic                 flow_tx_allow_q;
    logic                 rx_data_accept_q;
    logic                 rx_flow_accept_q;
    logic                 tx_irq_q;
    logic                 modem_irq_q;
    logic                 ir_rx_data_q;
    logic                 rts_n_q;
    logic                 dtr_n_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire aw_take  = awvalid && awready_q;
    wire w_take   = wvalid && wready_q;
    wire ar_take  = arvalid && arready_q;
    wire wr_fire  = !awready_q && !wready_q && !bvalid_q;
    wire wr_lane  = wr_fire && w_lane0_q;
    wire enh_en   = enhanced_q[u485_pkg::ENH_EN_BIT];
    wire wr_turn  = wr_lane && (aw_addr_q == u485_pkg::OFF_TURN_CTL) && enh_en; // R3 R20
    wire wr_scr   = wr_lane && (aw_addr_q == u485_pkg::OFF_SCRATCH);
    wire wr_feat  = wr_lane && (aw_addr_q == u485_pkg::OFF_FEATURE);
    wire wr_enh   = wr_lane && (aw_addr_q == u485_pkg::OFF_ENHANCED);
    wire wr_mcr   = wr_lane && (aw_addr_q == u485_pkg::OFF_MODEM_CTL);
    wire wr_hit   = (aw_addr_q == u485_pkg::OFF_TURN_CTL) || (aw_addr_q == u485_pkg::OFF_SCRATCH)
                 || (aw_addr_q == u485_pkg::OFF_FEATURE) || (aw_addr_q == u485_pkg::OFF_ENHANCED)
                 || (aw_addr_q == u485_pkg::OFF_MODEM_CTL);
    wire rd_stat  = ar_take && (araddr == u485_pkg::OFF_TURN_CTL);
    wire [7:0] stat_byte = {3'h0, cts_q, 3'h0, dcts_q};
    wire rd_hit   = (araddr == u485_pkg::OFF_TURN_CTL) || (araddr == u485_pkg::OFF_SCRATCH)
                 || (araddr == u485_pkg::OFF_FEATURE) || (araddr == u485_pkg::OFF_ENHANCED)
                 || (araddr == u485_pkg::OFF_MODEM_CTL);
    // turnaround/disable control is write-only; its read offset shows modem status
    wire [7:0] rd_byte = (araddr == u485_pkg::OFF_TURN_CTL)  ? stat_byte
                       : (araddr == u485_pkg::OFF_SCRATCH)   ? scratch_q
                       : (araddr == u485_pkg::OFF_FEATURE)   ? feature_q
                       : (araddr == u485_pkg::OFF_ENHANCED)  ? enhanced_q
                       : (araddr == u485_pkg::OFF_MODEM_CTL) ? modem_ctl_q
                       : 8'h00;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire [3:0] turn_dly = turn_ctl_q[7:u485_pkg::TURN_DLY_LSB];
    wire tx_dis   = turn_ctl_q[u485_pkg::TX_DIS_BIT];
    wire rx_dis   = turn_ctl_q[u485_pkg::RX_DIS_BIT];
    wire tx_mode  = turn_ctl_q[u485_pkg::TX_MODE_BIT];
    wire rx_mode  = turn_ctl_q[u485_pkg::RX_MODE_BIT];
    wire rs485_en = feature_q[u485_pkg::FEAT_RS485_BIT];
    wire ir_inv   = feature_q[u485_pkg::FEAT_IRPOL_BIT];
    wire flow_sel = modem_ctl_q[u485_pkg::MCR_SEL_BIT];
    wire auto_en  = modem_ctl_q[u485_pkg::MCR_AUTO_BIT];
    wire tx_idle  = tsr_empty && tx_fifo_empty;
    wire idle_rise = tx_idle && !tx_idle_q;   // last stop bit has left the shifter
    wire cts_now  = !cts_n;
    wire turn_done;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= u485_pkg::RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                wready_q  <= 1'b0;
                w_data_q  <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? u485_pkg::RESP_OKAY : u485_pkg::RESP_SLVERR;
            end
            if (bvalid_q && bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= u485_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h00_0000, rd_byte};
            rresp_q   <= rd_hit ? u485_pkg::RESP_OKAY : u485_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            turn_ctl_q  <= u485_pkg::RST_TURN_CTL;
            scratch_q   <= u485_pkg::RST_SCRATCH;   // R12
            feature_q   <= u485_pkg::RST_FEATURE;
            enhanced_q  <= u485_pkg::RST_ENHANCED;
            modem_ctl_q <= u485_pkg::RST_MODEM_CTL;
        end else begin
            if (wr_turn) turn_ctl_q  <= w_data_q;   // R3 R20
            if (wr_scr)  scratch_q   <= w_data_q;   // R12
            if (wr_feat) feature_q   <= w_data_q;
            if (wr_enh)  enhanced_q  <= w_data_q;
            if (wr_mcr)  modem_ctl_q <= w_data_q;
        end
    end

    // ------------------------------------------------------------
    // modem status: delta cts, set wins over read clear
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cts_q  <= 1'b0;
            dcts_q <= 1'b0;
        end else begin
            cts_q  <= cts_now;
            if (cts_now != cts_q) dcts_q <= 1'b1;   // R1
            else if (rd_stat)     dcts_q <= 1'b0;   // R21
        end
    end

    // ------------------------------------------------------------
    // rs485 direction sequencer
    // ------------------------------------------------------------
    always_comb begin
        dir_d = dir_q;
        unique case (dir_q)
            u485_pkg::DIR_IDLE: if (tx_load) dir_d = u485_pkg::DIR_TX;   // R16 R18
            u485_pkg::DIR_TX:   if (idle_rise) dir_d = u485_pkg::DIR_TURN;
            u485_pkg::DIR_TURN: begin
                if (tx_load)        dir_d = u485_pkg::DIR_TX;   // new byte cancels turnaround
                else if (turn_done) dir_d = u485_pkg::DIR_IDLE; // R2 R16
            end
            default:            dir_d = u485_pkg::DIR_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q     <= u485_pkg::DIR_IDLE;
            tx_idle_q <= 1'b1;
        end else begin
            dir_q     <= dir_d;
            tx_idle_q <= tx_idle;
        end
    end

    // bit-time delay counted from the baud period
    u485_turn #(
        .BIT_CYCLES (BIT_CYCLES)   // R22
    ) u_turn (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   ((dir_q == u485_pkg::DIR_TX) && idle_rise),   // R2
        .cancel  (tx_load),
        .delay   (turn_dly),
        .done    (turn_done)
    );

    // ------------------------------------------------------------
    // transmit and receive disable
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_dis_prev_q <= 1'b0;
            flow_pend_q   <= 1'b0;
            rx_halt_q     <= 1'b0;
        end else begin
            tx_dis_prev_q <= tx_dis;
            // a flow character queued at disable time still goes out once
            if (tx_dis && !tx_dis_prev_q) flow_pend_q <= flow_char_pending;   // R10
            else if (flow_char_sent || !tx_dis) flow_pend_q <= 1'b0;
            // halt only between characters; re-enable is immediate, so a busy line
            // at that moment may deliver garbage, which software must avoid
            if (!rx_dis)       rx_halt_q <= 1'b0;   // R7
            else if (!rx_busy) rx_halt_q <= 1'b1;   // R6
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_halt_q        <= 1'b0;
            flow_tx_allow_q  <= 1'b1;
            rx_data_accept_q <= 1'b1;
            rx_flow_accept_q <= 1'b1;
            tx_irq_q         <= 1'b0;
            modem_irq_q      <= 1'b0;
            ir_rx_data_q     <= 1'b0;
            rts_n_q          <= 1'b1;
            dtr_n_q          <= 1'b1;
        end else begin
            tx_halt_q        <= tx_dis;                                  // R4 R5
            flow_tx_allow_q  <= !tx_dis || tx_mode || flow_pend_q;       // R10
            rx_data_accept_q <= !rx_halt_q;
            rx_flow_accept_q <= !rx_halt_q || rx_mode;                   // R11
            tx_irq_q         <= enhanced_q[u485_pkg::ENH_TXI_BIT]
                              && (rs485_en ? tx_idle : thr_empty);       // R17
            modem_irq_q      <= enhanced_q[u485_pkg::ENH_MSI_BIT] && dcts_q;   // R1
            ir_rx_data_q     <= ir_rx_in ^ ir_inv;                       // R19
            // rs485 direction takes the selected pin over auto flow control
            if (rs485_en && !flow_sel) rts_n_q <= (dir_q != u485_pkg::DIR_IDLE);   // R14 R15
            else rts_n_q <= !(modem_ctl_q[u485_pkg::MCR_RTS_BIT] && !(auto_en && !flow_sel && auto_flow_deassert));
            if (rs485_en && flow_sel) dtr_n_q <= (dir_q != u485_pkg::DIR_IDLE);    // R14 R15
            else dtr_n_q <= !(modem_ctl_q[u485_pkg::MCR_DTR_BIT] && !(auto_en && flow_sel && auto_flow_deassert));
        end
    end

    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    assign awready         = awready_q;
    assign wready          = wready_q;
    assign bvalid          = bvalid_q;
    assign bresp           = bresp_q;
    assign arready         = arready_q;
    assign rvalid          = rvalid_q;
    assign rdata           = rdata_q;
    assign rresp           = rresp_q;
    assign tx_halt         = tx_halt_q;
    assign flow_tx_allow   = flow_tx_allow_q;
    assign rx_halt         = rx_halt_q;         // receive fifo reads are never gated here: R9
    assign rx_data_accept  = rx_data_accept_q;
    assign rx_flow_accept  = rx_flow_accept_q;
    assign trigger_table   = feature_q[7:u485_pkg::FEAT_TBL_LSB];   // R13
    assign next_level_hyst = (feature_q[7:u485_pkg::FEAT_TBL_LSB] != u485_pkg::TABLE_D);   // R13
    assign tx_irq          = tx_irq_q;
    assign modem_irq       = modem_irq_q;
    assign ir_rx_data      = ir_rx_data_q;
    assign rts_n           = rts_n_q;
    assign dtr_n           = dtr_n_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    delta_cts_set_a: assert property ($changed(cts_n) |-> ##1 dcts_q) // R1
        else $error("delta cts not set after cts change");
    turn_zero_a: assert property (dir_q == u485_pkg::DIR_TX && idle_rise && turn_dly == 4'h0 && !tx_load
        ##1 !tx_load [*3] |-> dir_q == u485_pkg::DIR_IDLE) // R2
        else $error("zero turnaround did not end");
    turn_gate_a: assert property (wr_fire && !enh_en |=> $stable(turn_ctl_q)) // R3
        else $error("turnaround written while enhanced writes off");
    tx_halt_a: assert property ($rose(tx_dis) |=> tx_halt_q [*2]) // R4
        else $error("transmitter not halted");
    rx_finish_a: assert property (rx_dis && rx_busy && !rx_halt_q |=> !rx_halt_q) // R6
        else $error("receiver halted mid character");
    flow_rx_a: assert property (rx_halt_q && rx_mode |=> rx_flow_accept_q && !rx_data_accept_q) // R11
        else $error("flow characters not accepted in mode one");
    scratch_rst_a: assert property ($rose(aresetn) |-> scratch_q == 8'hFF) // R12
        else $error("scratch not ff after reset");
    rs485_pin_a: assert property (rs485_en && !flow_sel && dir_q == u485_pkg::DIR_TX |=> rts_n_q) // R14
        else $error("direction pin not high while sending");
    tx_irq_a: assert property (rs485_en && !tsr_empty |=> !tx_irq_q) // R17
        else $error("tx interrupt while shifter busy");
    ir_pol_a: assert property (ir_inv && $stable(ir_inv) |=> ir_rx_data_q == !$past(ir_rx_in)) // R19
        else $error("infrared polarity wrong");

    turn_done_c: cover property (dir_q == u485_pkg::DIR_TURN ##1 dir_q == u485_pkg::DIR_IDLE);
    write_done_c: cover property (bvalid_q && bready && bresp_q == u485_pkg::RESP_OKAY);
    dcts_read_c: cover property (dcts_q && rd_stat ##1 !dcts_q);

endmodule : u485_ctl

`default_nettype wire

// File: logic/u485_pkg.sv
package u485_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TURN_CTL  = 8'h00; // write: turnaround/disable control, read: modem status
    localparam logic [7:0] OFF_SCRATCH   = 8'h04;
    localparam logic [7:0] OFF_FEATURE   = 8'h08;
    localparam logic [7:0] OFF_ENHANCED  = 8'h0C;
    localparam logic [7:0] OFF_MODEM_CTL = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TURN_DLY_LSB   = 4;   // turnaround delay [7:4]
    localparam int TX_DIS_BIT     = 3;
    localparam int RX_DIS_BIT     = 2;
    localparam int TX_MODE_BIT    = 1;
    localparam int RX_MODE_BIT    = 0;
    localparam int STAT_CTS_BIT   = 4;   // modem status: cts level
    localparam int STAT_DCTS_BIT  = 0;   // modem status: delta cts
    localparam int FEAT_TBL_LSB   = 6;   // trigger table [7:6]
    localparam int FEAT_RS485_BIT = 5;
    localparam int FEAT_IRPOL_BIT = 4;
    localparam int ENH_EN_BIT     = 4;
    localparam int ENH_MSI_BIT    = 3;   // modem status interrupt enable
    localparam int ENH_TXI_BIT    = 1;   // transmit interrupt enable
    localparam int MCR_AUTO_BIT   = 6;   // auto rts/dtr flow control enable
    localparam int MCR_SEL_BIT    = 2;   // 0: rts pin, 1: dtr pin
    localparam int MCR_RTS_BIT    = 1;
    localparam int MCR_DTR_BIT    = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TURN_CTL  = 8'h00;
    localparam logic [7:0] RST_SCRATCH   = 8'hFF;
    localparam logic [7:0] RST_FEATURE   = 8'h00;
    localparam logic [7:0] RST_ENHANCED  = 8'h00;
    localparam logic [7:0] RST_MODEM_CTL = 8'h00;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // trigger table d: no next-level hysteresis
    localparam logic [1:0] TABLE_D = 2'h3;

    // ------------------------------------------------------------
    // direction state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_TX   = 3'b010,
        DIR_TURN = 3'b100
    } u485_dir_t;

endpackage : u485_pkg

// File: logic/u485_turn.sv
`timescale 1ns/10ps
`default_nettype none

module u485_turn #(
    parameter int unsigned BIT_CYCLES = 16
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       start,
    input  wire logic       cancel,
    input  wire logic [3:0] delay,
    // result
    output logic            done
);

    localparam logic [15:0] DIV_LAST = 16'(BIT_CYCLES - 1);

    logic [15:0] div_q;
    logic [3:0]  bits_q;
    logic        busy_q;
    logic        done_q;

    // divider enable marks one serial bit period
    wire bit_tick = busy_q && (div_q == DIV_LAST);
    wire finish   = busy_q && (bits_q == 4'h0) && !cancel;

    // ------------------------------------------------------------
    // bit-time counter
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q  <= 16'h0000;
            bits_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= finish;
            if (cancel || finish) begin
                busy_q <= 1'b0;
            end else if (start) begin
                busy_q <= 1'b1;
                bits_q <= delay;  // binary count of bit times
                div_q  <= 16'h0000;
            end else if (bit_tick) begin
                div_q  <= 16'h0000;
                bits_q <= bits_q - 4'h1;
            end else if (busy_q) begin
                div_q  <= div_q + 16'h0001;
            end
        end
    end

    assign done = done_q;

endmodule : u485_turn

`default_nettype wire

// File: verification/u485_line.sv
`timescale 1ns/10ps
`default_nettype none
// far side of the core: one byte holds the shifter busy for a few cycles
module u485_line (
    // clock
    input  wire logic aclk,
    // core handshake
    input  wire logic tx_load,
    input  wire logic tx_halt,
    // status
    output logic      tsr_empty
);
    logic [3:0] cnt_q = 4'h0;
    // a halted shifter keeps its count, so the byte stays queued
    always_ff @(posedge aclk) begin
        if (tx_load) cnt_q <= 4'h6;
        else if (cnt_q != 4'h0 && !tx_halt) cnt_q <= cnt_q - 4'h1;
    end
    assign tsr_empty = (cnt_q == 4'h0);
endmodule : u485_line
`default_nettype wire

// File: verification/u485_ctl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module u485_ctl_bench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic tx_load = 0, cts_n = 1, ir_rx_in = 0, tsr_e, awready, wready, bvalid, arready, rvalid;
    logic flow_char_pending = 0, rx_busy = 0, flow_tx_allow, rx_halt, rx_data_accept, rx_flow_accept;
    logic tx_irq, modem_irq, dtr_n;
    logic [3:0] wstrb = 4'hF;
    logic tx_halt, ir_rx_data, rts_n, hyst;
    logic [1:0] bresp, rresp, tbl;
    int n_fail = 0, checks = 0;
    always #2 aclk = ~aclk;
    u485_ctl #(.BIT_CYCLES(2)) uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .tx_load(tx_load), .thr_empty(tsr_e), .tx_fifo_empty(tsr_e), .tsr_empty(tsr_e),
        .flow_char_pending(flow_char_pending), .flow_char_sent(1'b0), .rx_busy(rx_busy),
        .auto_flow_deassert(1'b0), .tx_halt(tx_halt), .flow_tx_allow(flow_tx_allow), .rx_halt(rx_halt),
        .rx_data_accept(rx_data_accept), .rx_flow_accept(rx_flow_accept), .trigger_table(tbl),
        .next_level_hyst(hyst), .tx_irq(tx_irq), .modem_irq(modem_irq), .cts_n(cts_n),
        .ir_rx_in(ir_rx_in), .ir_rx_data(ir_rx_data), .rts_n(rts_n), .dtr_n(dtr_n));
    u485_line line (.aclk(aclk), .tx_load(tx_load), .tx_halt(tx_halt), .tsr_empty(tsr_e));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    task load_byte;
        tx_load <= 1;
        @(posedge aclk);
        tx_load <= 0;
    endtask : load_byte
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // hang guard, well beyond the roughly 130 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h04, 32'hFF, 2'h0);
        wr(8'h04, 8'h5A);
        rd(8'h04, 32'h5A, 2'h0);
        wstrb <= 4'h0;
        wr(8'h04, 8'hA5); // byte lane 0 off: write must be dropped
        wstrb <= 4'hF;
        rd(8'h04, 32'h5A, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h00, 8'h08);
        // enhanced writes still off, so this tx disable write is dropped and tx_halt stays low
        @(posedge aclk);
        chk("tx_halt", 0, tx_halt);
        cts_n <= 0;
        @(posedge aclk);
        rd(8'h00, 32'h11, 2'h0);
        rd(8'h00, 32'h10, 2'h0);
        $display("test registers done");
        wr(8'h0C, 8'h10); wr(8'h08, 8'h20); wr(8'h00, 8'h10);
        load_byte();
        repeat (3) @(posedge aclk);
        chk("dir on load", 1, rts_n);
        repeat (8) @(posedge aclk);
        chk("dir in turn", 1, rts_n);
        repeat (4) @(posedge aclk);
        chk("dir after turn", 0, rts_n);
        wr(8'h00, 8'h08);
        load_byte();
        repeat (20) @(posedge aclk);
        chk("dir halted", 1, rts_n);
        chk("flow blocked", 0, flow_tx_allow);
        wr(8'h00, 8'h00);
        repeat (20) @(posedge aclk);
        chk("dir resumed", 0, rts_n);
        wr(8'h10, 8'h04);
        @(posedge aclk);
        chk("dtr as dir", 0, dtr_n);
        chk("rts freed", 1, rts_n);
        $display("test direction done");
        wr(8'h08, 8'hD0); wr(8'h0C, 8'h1A); ir_rx_in <= 1; cts_n <= 1;
        repeat (3) @(posedge aclk);
        chk("ir inverted", 0, ir_rx_data);
        chk("table", 3, tbl);
        chk("hyst", 0, hyst);
        chk("modem irq", 1, modem_irq);
        chk("tx irq", 1, tx_irq);
        $display("test feature done");
        // disable with a flow character queued and a character arriving
        flow_char_pending <= 1;
        rx_busy <= 1;
        wr(8'h00, 8'h0C);
        repeat (2) @(posedge aclk);
        chk("flow pending", 1, flow_tx_allow);
        chk("rx mid char", 0, rx_halt);
        rx_busy <= 0;
        repeat (3) @(posedge aclk);
        chk("rx halted", 1, rx_halt);
        chk("rx flow off", 0, rx_flow_accept);
        wr(8'h00, 8'h0D);
        repeat (2) @(posedge aclk);
        chk("rx flow on", 1, rx_flow_accept);
        chk("rx data off", 0, rx_data_accept);
        wr(8'h00, 8'h00);
        @(posedge aclk);
        chk("rx resumed", 0, rx_halt);
        $display("test disable done");
        give_verdict();
    end
endmodule : u485_ctl_bench
`default_nettype wire
